/* ssm_top.sv */
`timescale 1ns/1ps
module ssm_top
    import ssm_pkg::*;
#(
    parameter int unsigned RETRY_CYCLES = SSM_RETRY_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic enable_n_i,
    input wire logic inhibit_n_i,
    input wire logic fault_i,
    input wire logic overtemp_fault_i,
    input wire logic frame_start_i,
    input wire logic frame_stop_i,
    input wire logic rx_bit_valid_i,
    input wire logic rx_bit_i,
    input wire logic tx_take_i,
    output logic tx_valid_o,
    output logic tx_bit_o,
    output logic outputs_on_o,
    output logic shutdown_o,
    output logic event_msg_o,
    output logic [7:0] status_o
);

    typedef struct packed {
        logic [1:0] pin_meta;
        logic [1:0] pin_sync;
        logic ovr;
        logic fail;
        logic otw;
        logic prio;
        logic soft_inh_n;
        logic soft_en_n;
        ssm_pwr_t pwr;
        logic ot_latch;
        logic [31:0] retry_cnt;
        logic evt;
        logic outs_on;
        logic [7:0] cmd;
        logic [2:0] nargs;
        logic [0:SSM_ARG_SLOTS-1][7:0] arg;
        logic [7:0] sum;
        ssm_tx_t tx;
        logic [0:SSM_RESP_MAX-1][7:0] resp;
        logic [3:0] resp_len;
        logic [3:0] resp_idx;
        logic [2:0] bit_idx;
        logic [7:0] tx_sh;
    } ssm_state_t;

    ssm_state_t s;
    ssm_state_t next_s;

    ssm_byte_if rx_bus ();
    ssm_sdr_rec_t sdr_rec;

    logic wr_single;
    logic wr_triple;
    logic rd_status;
    logic rd_sdr;
    logic en_act;
    logic inh_act;
    logic any_fault;
    logic [7:0] wr_data;
    logic [0:SSM_RESP_MAX-1][7:0] resp_buf;
    logic [3:0] resp_len;

    ssm_rx u_rx (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .frame_start_i(frame_start_i),
        .bit_valid_i(rx_bit_valid_i),
        .bit_i(rx_bit_i),
        .byte_o(rx_bus)
    );

    ssm_sdr u_sdr (
        .sensor_i(s.arg[0]),
        .record_o(sdr_rec)
    );

    function automatic logic [7:0] status_byte(input ssm_state_t st);
        logic [7:0] b;
        b = 8'h00;
        b[SSM_BIT_OVR] = st.ovr;
        b[SSM_BIT_FAIL] = st.fail;
        b[SSM_BIT_OTW] = st.otw;
        b[SSM_BIT_PRIO] = st.prio;
        b[SSM_BIT_SOFT_INH_N] = st.soft_inh_n;
        b[SSM_BIT_SOFT_EN_N] = st.soft_en_n;
        b[SSM_BIT_PIN_INH] = st.pin_sync[1];
        b[SSM_BIT_PIN_EN] = st.pin_sync[0];
        return b;
    endfunction

    // Byte that makes the first len-1 bytes plus itself sum to zero
    function automatic logic [7:0] zero_sum(
        input logic [0:SSM_RESP_MAX-1][7:0] buf_in,
        input logic [3:0] len
    );
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < SSM_RESP_MAX; i++) begin
            if (4'(i) < len - 4'h1) begin
                acc = acc + buf_in[i];
            end
        end
        return 8'h00 - acc;
    endfunction

    // Frame decode, valid only on the stop strobe
    always_comb begin
        wr_single = (s.cmd == SSM_CMD_STATUS) && (s.nargs == SSM_NARG_SINGLE)
                    && (s.sum == 8'h00);
        wr_triple = (s.cmd == SSM_CMD_STATUS) && (s.nargs == SSM_NARG_TRIPLE)
                    && (s.sum == 8'h00) && (s.arg[0] == s.arg[1])
                    && (s.arg[1] == s.arg[2]);
        rd_status = (s.cmd == SSM_CMD_STATUS) && (s.nargs == SSM_NARG_READ);
        rd_sdr = (s.cmd == SSM_CMD_SDR) && (s.nargs == SSM_NARG_SINGLE)
                 && (s.sum == 8'h00);
        wr_data = s.arg[0];
        any_fault = fault_i || overtemp_fault_i;
        resp_buf = '0;
        resp_len = SSM_LEN_STATUS;
        if (rd_sdr) begin
            resp_len = SSM_LEN_SDR;
            resp_buf[0] = s.cmd;
            resp_buf[1] = s.arg[0];
            for (int i = 0; i < SSM_SDR_FIELDS; i++) begin
                resp_buf[i + 2] = sdr_rec[i];
            end
        end else begin
            resp_buf[0] = s.cmd;
            resp_buf[1] = status_byte(s);
        end
        resp_buf[resp_len - 4'h1] = zero_sum(resp_buf, resp_len);
    end

    always_comb begin
        next_s = s;
        next_s.evt = 1'b0;

        // Pins cross from the backplane; first flop feeds only the second
        next_s.pin_meta = {inhibit_n_i, enable_n_i};
        next_s.pin_sync = s.pin_meta;

        // Gather the incoming frame
        // Empty frame must not replay the previous command
        if (frame_start_i) begin
            next_s.cmd = 8'h00;
            next_s.nargs = 3'h0;
            next_s.sum = 8'h00;
        end
        if (rx_bus.valid) begin
            if (rx_bus.first) begin
                next_s.cmd = rx_bus.data;
                next_s.nargs = 3'h0;
                next_s.sum = rx_bus.data;
            end else begin
                if (s.nargs < 3'(SSM_ARG_SLOTS)) begin
                    next_s.arg[s.nargs[1:0]] = rx_bus.data;
                end
                if (s.nargs != SSM_NARG_MAX) begin
                    next_s.nargs = s.nargs + 3'h1;
                end
                next_s.sum = s.sum + rx_bus.data;
            end
        end

        // Status writes; bits 0 and 1 are never written
        if (frame_stop_i && (wr_single || wr_triple)) begin
            next_s.fail = wr_data[SSM_BIT_FAIL];
            next_s.otw = wr_data[SSM_BIT_OTW];
            next_s.prio = wr_data[SSM_BIT_PRIO];
            next_s.soft_inh_n = wr_data[SSM_BIT_SOFT_INH_N];
            next_s.soft_en_n = wr_data[SSM_BIT_SOFT_EN_N];
            next_s.ovr = wr_triple ? wr_data[SSM_BIT_OVR] : 1'b0;
        end

        // Hardware clears win over a same-cycle manager set
        if (fault_i) begin
            next_s.fail = 1'b0;
        end
        if (overtemp_fault_i) begin
            next_s.otw = 1'b0;
        end
        next_s.evt = any_fault;

        // Shutdown and recovery
        case (s.pwr)
            SSM_PWR_RUN: begin
                if (any_fault && !s.ovr) begin
                    next_s.pwr = SSM_PWR_SHUT;
                    next_s.ot_latch = overtemp_fault_i;
                    next_s.retry_cnt = 32'h0;
                end
            end
            SSM_PWR_SHUT: begin
                if (s.ovr) begin
                    next_s.pwr = SSM_PWR_RUN;
                    next_s.ot_latch = 1'b0;
                end else if (any_fault) begin
                    next_s.ot_latch = s.ot_latch || overtemp_fault_i;
                    next_s.retry_cnt = 32'h0;
                end else if (!s.ot_latch) begin
                    // Overtemp stays down until reset or override
                    if (s.retry_cnt == 32'(RETRY_CYCLES - 1)) begin
                        next_s.pwr = SSM_PWR_RUN;
                    end else begin
                        next_s.retry_cnt = s.retry_cnt + 32'h1;
                    end
                end
            end
            default: begin
                next_s.pwr = SSM_PWR_SHUT;
            end
        endcase

        // Output control from pins or from software
        en_act = next_s.prio ? !next_s.soft_en_n : !s.pin_sync[0];
        inh_act = next_s.prio ? !next_s.soft_inh_n : !s.pin_sync[1];
        next_s.outs_on = en_act && !inh_act && (next_s.pwr == SSM_PWR_RUN);

        // Response serialiser
        case (s.tx)
            SSM_TX_IDLE: begin
                if (frame_stop_i && (rd_status || rd_sdr)) begin
                    next_s.tx = SSM_TX_SEND;
                    next_s.resp = resp_buf;
                    next_s.resp_len = resp_len;
                    next_s.resp_idx = 4'h0;
                    next_s.bit_idx = 3'h0;
                    next_s.tx_sh = resp_buf[0];
                end
            end
            SSM_TX_SEND: begin
                if (tx_take_i) begin
                    next_s.tx_sh = {s.tx_sh[6:0], 1'b0};
                    next_s.bit_idx = s.bit_idx + 3'h1;
                    if (s.bit_idx == SSM_LAST_BIT) begin
                        if (s.resp_idx == s.resp_len - 4'h1) begin
                            next_s.tx = SSM_TX_IDLE;
                        end else begin
                            next_s.resp_idx = s.resp_idx + 4'h1;
                            next_s.tx_sh = s.resp[s.resp_idx + 4'h1];
                        end
                    end
                end
            end
            default: begin
                next_s.tx = SSM_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= '0;
            s.pin_meta <= SSM_RST_PINS;
            s.pin_sync <= SSM_RST_PINS;
            s.ovr <= SSM_RST_OVR;
            s.fail <= SSM_RST_FAIL;
            s.otw <= SSM_RST_OTW;
            s.prio <= SSM_RST_PRIO;
            s.soft_inh_n <= SSM_RST_SOFT_INH_N;
            s.soft_en_n <= SSM_RST_SOFT_EN_N;
            s.pwr <= SSM_PWR_RUN;
            s.tx <= SSM_TX_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign tx_valid_o = (s.tx == SSM_TX_SEND);
    assign tx_bit_o = s.tx_sh[7];
    assign outputs_on_o = s.outs_on;
    assign shutdown_o = (s.pwr == SSM_PWR_SHUT);
    assign event_msg_o = s.evt;
    assign status_o = status_byte(s);

endmodule

/* ssm_pkg.sv */
package ssm_pkg;

    // Status register field positions
    localparam int SSM_BIT_PIN_EN = 0;
    localparam int SSM_BIT_PIN_INH = 1;
    localparam int SSM_BIT_SOFT_EN_N = 2;
    localparam int SSM_BIT_SOFT_INH_N = 3;
    localparam int SSM_BIT_PRIO = 4;
    localparam int SSM_BIT_OTW = 5;
    localparam int SSM_BIT_FAIL = 6;
    localparam int SSM_BIT_OVR = 7;

    // Reset values of the stored status bits
    localparam logic SSM_RST_OVR = 1'b0;
    localparam logic SSM_RST_FAIL = 1'b0;
    localparam logic SSM_RST_OTW = 1'b0;
    localparam logic SSM_RST_PRIO = 1'b0;
    localparam logic SSM_RST_SOFT_INH_N = 1'b0;
    localparam logic SSM_RST_SOFT_EN_N = 1'b0;
    // Pin synchronisers start at the inactive (high) level
    localparam logic [1:0] SSM_RST_PINS = 2'h3;

    // Command bytes and the all-on status write value
    localparam logic [7:0] SSM_CMD_STATUS = 8'h55;
    localparam logic [7:0] SSM_CMD_SDR = 8'h5a;
    localparam logic [7:0] SSM_STATUS_ALL_ON = 8'h18;

    // Argument byte counts (bytes after the command, checksum included)
    localparam logic [2:0] SSM_NARG_READ = 3'h0;
    localparam logic [2:0] SSM_NARG_SINGLE = 3'h2;
    localparam logic [2:0] SSM_NARG_TRIPLE = 3'h4;
    localparam logic [2:0] SSM_NARG_MAX = 3'h7;
    localparam int SSM_ARG_SLOTS = 4;

    // Response frame sizes
    localparam int SSM_RESP_MAX = 10;
    localparam logic [3:0] SSM_LEN_STATUS = 4'h3;
    localparam logic [3:0] SSM_LEN_SDR = 4'ha;
    localparam int SSM_SDR_FIELDS = 7;

    // Sensor data record field values
    localparam logic [7:0] SSM_SDR_SUPPORTED = 8'h01;
    localparam logic [7:0] SSM_SDR_UNSUPPORTED = 8'h00;
    localparam logic [7:0] SSM_EVT_THRESHOLD = 8'h01;
    localparam logic [7:0] SSM_EVT_PREDICTIVE = 8'h04;
    localparam logic [7:0] SSM_EVT_LIMIT = 8'h05;
    localparam logic [7:0] SSM_EVT_SPECIFIC = 8'h6f;

    // Fault recovery retry interval
    localparam int SSM_CLK_KHZ = 125000;
    localparam int SSM_RETRY_MS = 1000;
    localparam int SSM_RETRY_CYCLES = SSM_RETRY_MS * SSM_CLK_KHZ;

    localparam int SSM_BITS_PER_BYTE = 8;
    localparam logic [2:0] SSM_LAST_BIT = 3'h7;

    typedef enum logic [0:0] {
        SSM_PWR_RUN,
        SSM_PWR_SHUT
    } ssm_pwr_t;

    typedef enum logic [0:0] {
        SSM_TX_IDLE,
        SSM_TX_SEND
    } ssm_tx_t;

    typedef logic [0:SSM_SDR_FIELDS-1][7:0] ssm_sdr_rec_t;

endpackage

/* ssm_byte_if.sv */
`timescale 1ns/1ps
interface ssm_byte_if;
    logic valid;
    logic first;
    logic [7:0] data;
    modport src (output valid, output first, output data);
    modport dst (input valid, input first, input data);
endinterface

/* ssm_rx.sv */
`timescale 1ns/1ps
module ssm_rx
    import ssm_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic frame_start_i,
    input wire logic bit_valid_i,
    input wire logic bit_i,
    ssm_byte_if.src byte_o
);

    typedef struct packed {
        logic [6:0] sh;
        logic [2:0] cnt;
        logic is_first;
        logic valid;
        logic first;
        logic [7:0] data;
    } ssm_rx_state_t;

    ssm_rx_state_t s;
    ssm_rx_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.valid = 1'b0;
        if (frame_start_i) begin
            next_s.cnt = 3'h0;
            next_s.is_first = 1'b1;
        end else if (bit_valid_i) begin
            next_s.sh = {s.sh[5:0], bit_i};
            if (s.cnt == SSM_LAST_BIT) begin
                next_s.data = {s.sh, bit_i};
                next_s.valid = 1'b1;
                next_s.first = s.is_first;
                next_s.is_first = 1'b0;
                next_s.cnt = 3'h0;
            end else begin
                next_s.cnt = s.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign byte_o.valid = s.valid;
    assign byte_o.first = s.first;
    assign byte_o.data = s.data;

endmodule

/* ssm_sdr.sv */
`timescale 1ns/1ps
module ssm_sdr
    import ssm_pkg::*;
(
    input wire logic [7:0] sensor_i,
    output ssm_sdr_rec_t record_o
);

    // Fields: supported, type, event type, M, B, K1, K2 (signed bytes)
    function automatic ssm_sdr_rec_t sdr_lookup(input logic [7:0] num);
        ssm_sdr_rec_t r;
        r = '0;
        r[0] = SSM_SDR_SUPPORTED;
        r[2] = SSM_EVT_THRESHOLD;
        case (num)
            8'h02: r[1:2] = {8'hf2, SSM_EVT_PREDICTIVE};
            8'h03: r[1:2] = {8'h02, SSM_EVT_LIMIT};
            8'h04: r[1:2] = {8'hf3, SSM_EVT_SPECIFIC};
            8'h07: r[1:6] = {8'h02, 8'h01, 8'h14, 8'h5a, 8'h01, 8'hfe};
            8'h08: r[1:6] = {8'h02, 8'h01, 8'h14, 8'h5a, 8'h02, 8'hfd};
            8'h0a: r[1:6] = {8'h02, 8'h01, 8'h0a, 8'h23, 8'h02, 8'hfd};
            8'h0b: r[1:6] = {8'h02, 8'h01, 8'h0a, 8'h14, 8'h02, 8'hfd};
            8'h0c: r[1:6] = {8'h02, 8'h01, 8'h14, 8'h5a, 8'h02, 8'hfd};
            8'h0d: r[1:6] = {8'h02, 8'h01, 8'hec, 8'ha6, 8'h02, 8'hfd};
            8'h0e: r[1:6] = {8'h03, 8'h01, 8'h04, 8'h00, 8'h00, 8'hff};
            8'h0f: r[1:6] = {8'h03, 8'h01, 8'h04, 8'h00, 8'h00, 8'hff};
            8'h11: r[1:6] = {8'h03, 8'h01, 8'h14, 8'h00, 8'h00, 8'hfe};
            8'h12: r[1:6] = {8'h01, 8'h01, 8'h01, 8'h14, 8'h01, 8'h00};
            8'h13: r[1:6] = {8'h01, 8'h01, 8'h01, 8'h14, 8'h01, 8'h00};
            8'h15: r[1:6] = {8'h0b, 8'h01, 8'h32, 8'h00, 8'h00, 8'hff};
            8'h16: r[1:6] = {8'h0b, 8'h01, 8'h28, 8'h00, 8'h00, 8'hff};
            8'h18: r[1:6] = {8'h0b, 8'h01, 8'h0a, 8'h00, 8'h00, 8'hff};
            8'h19: r[1:6] = {8'h03, 8'h01, 8'h14, 8'h00, 8'h00, 8'hfe};
            8'h1a: r[1:6] = {8'h03, 8'h01, 8'h14, 8'h00, 8'h00, 8'hfd};
            8'h1b: r[1:6] = {8'h03, 8'h01, 8'h14, 8'h00, 8'h00, 8'hfd};
            8'h1c: r[1:6] = {8'h0b, 8'h01, 8'h0a, 8'h00, 8'h00, 8'hff};
            // Rails 0x09, 0x10, 0x17 and unknown numbers
            default: r = '0;
        endcase
        r[0] = (r == '0) ? SSM_SDR_UNSUPPORTED : SSM_SDR_SUPPORTED;
        return r;
    endfunction

    // Constants let the manager evaluate (M*x + B*10^K1)*10^K2 itself
    assign record_o = sdr_lookup(sensor_i);

endmodule

/* ssm_chk_sva.sv */
`timescale 1ns/1ps
module ssm_chk
    import ssm_pkg::*;
#(
    parameter int unsigned RETRY_CYCLES = SSM_RETRY_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic enable_n_i,
    input wire logic inhibit_n_i,
    input wire logic fault_i,
    input wire logic overtemp_fault_i,
    input wire logic frame_start_i,
    input wire logic frame_stop_i,
    input wire logic rx_bit_valid_i,
    input wire logic rx_bit_i,
    input wire logic tx_take_i,
    input wire logic tx_valid_o,
    input wire logic tx_bit_o,
    input wire logic outputs_on_o,
    input wire logic shutdown_o,
    input wire logic event_msg_o,
    input wire logic [7:0] status_o
);
    // Synchroniser preset hides the pins for the first edges after reset
    logic [1:0] up_cnt;
    int unsigned shut_cnt;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            up_cnt <= 2'h0;
            shut_cnt <= 0;
        end else begin
            if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
            if (fault_i || overtemp_fault_i) shut_cnt <= 0;
            else if (shutdown_o) shut_cnt <= shut_cnt + 1;
        end
    end
    a_pin_enable: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        up_cnt == 2'h3 && $stable(enable_n_i)
        && $past(enable_n_i) == $past(enable_n_i, 2)
        |-> status_o[0] == enable_n_i)
        else $error("status bit 0 does not follow the enable pin");
    a_pin_inhibit: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        up_cnt == 2'h3 && $stable(inhibit_n_i)
        && $past(inhibit_n_i) == $past(inhibit_n_i, 2)
        |-> status_o[1] == inhibit_n_i)
        else $error("status bit 1 does not follow the inhibit pin");
    a_fault_event: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        fault_i || overtemp_fault_i |=> event_msg_o)
        else $error("no event message after a fault");
    a_fault_shut: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        fault_i && !status_o[7] |=> shutdown_o && !outputs_on_o)
        else $error("fault without override did not shut down");
    a_override_hold: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        status_o[7] && fault_i && !frame_stop_i && !$past(frame_stop_i)
        |=> !shutdown_o)
        else $error("shutdown while override is set");
    a_fail_clear: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        fault_i |=> !status_o[6])
        else $error("fail flag not cleared by fault");
    a_otw_clear: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        overtemp_fault_i |=> !status_o[5])
        else $error("overtemp flag not cleared by overtemp fault");
    a_retry_span: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $fell(shutdown_o) && !status_o[7] |-> shut_cnt == RETRY_CYCLES)
        else $error("shutdown released at the wrong time");
    a_override_source: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(status_o[7]) |-> $past(frame_stop_i) || $past(frame_stop_i, 2))
        else $error("override set without a frame");
    // Pin path lags the shown pin bits by one edge; soft bits do not
    a_output_select: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        outputs_on_o == (!shutdown_o && (status_o[4]
            ? (!status_o[2] && status_o[3])
            : (!$past(status_o[0]) && $past(status_o[1])))))
        else $error("outputs do not follow the selected controls");
endmodule
bind ssm_top ssm_chk #(.RETRY_CYCLES(RETRY_CYCLES)) u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .enable_n_i(enable_n_i),
    .inhibit_n_i(inhibit_n_i), .fault_i(fault_i),
    .overtemp_fault_i(overtemp_fault_i), .frame_start_i(frame_start_i),
    .frame_stop_i(frame_stop_i), .rx_bit_valid_i(rx_bit_valid_i),
    .rx_bit_i(rx_bit_i), .tx_take_i(tx_take_i), .tx_valid_o(tx_valid_o),
    .tx_bit_o(tx_bit_o), .outputs_on_o(outputs_on_o),
    .shutdown_o(shutdown_o), .event_msg_o(event_msg_o),
    .status_o(status_o));

/* ssm_mgr.sv */
`timescale 1ns/1ps
module ssm_mgr (
    input wire logic clk_i,
    input wire logic tx_valid_i,
    input wire logic tx_bit_i,
    output logic frame_start_o,
    output logic frame_stop_o,
    output logic bit_valid_o,
    output logic bit_o,
    output logic take_o
);
    logic [7:0] rx_q[$];
    initial begin
        frame_start_o = 1'b0;
        frame_stop_o = 1'b0;
        bit_valid_o = 1'b0;
        bit_o = 1'b0;
        take_o = 1'b0;
    end
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    // Frames longer than the command alone get a zero-sum checksum
    task automatic send(input logic [7:0] b[$]);
        logic [7:0] sum;
        sum = 8'h00;
        foreach (b[i]) sum = sum + b[i];
        if (b.size() > 1) b.push_back(8'h00 - sum);
        frame_start_o = 1'b1;
        tick();
        frame_start_o = 1'b0;
        foreach (b[i]) for (int k = 7; k >= 0; k--) begin
            bit_valid_o = 1'b1;
            bit_o = b[i][k];
            tick();
        end
        bit_valid_o = 1'b0;
        // Idle line shows no stale bit
        bit_o = ~bit_o;
        tick();
        tick();
        frame_stop_o = 1'b1;
        tick();
        frame_stop_o = 1'b0;
    endtask
    task automatic get(input int n);
        rx_q.delete();
        for (int w = 0; w < 20 && tx_valid_i !== 1'b1; w++) tick();
        for (int i = 0; i < n; i++) begin
            logic [7:0] v;
            for (int k = 7; k >= 0; k--) begin
                v[k] = tx_bit_i;
                take_o = 1'b1;
                tick();
            end
            rx_q.push_back(v);
        end
        take_o = 1'b0;
    endtask
endmodule

/* tb_supply_status_and_sensor_map.sv */
`timescale 1ns/1ps
module tb_supply_status_and_sensor_map;
    import ssm_pkg::*;
    localparam int unsigned RETRY = 20;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic enable_n_i = 1'b1;
    logic inhibit_n_i = 1'b1;
    logic fault_i = 1'b0;
    logic overtemp_fault_i = 1'b0;
    logic frame_start_i, frame_stop_i, rx_bit_valid_i, rx_bit_i, tx_take_i;
    logic tx_valid_o, tx_bit_o, outputs_on_o, shutdown_o, event_msg_o;
    logic [7:0] status_o;
    int err_total = 0;
    int samples_checked = 0;
    always #4 clk_i = ~clk_i;
    ssm_top #(.RETRY_CYCLES(RETRY)) u_dut (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .enable_n_i(enable_n_i),
        .inhibit_n_i(inhibit_n_i), .fault_i(fault_i),
        .overtemp_fault_i(overtemp_fault_i), .frame_start_i(frame_start_i),
        .frame_stop_i(frame_stop_i), .rx_bit_valid_i(rx_bit_valid_i),
        .rx_bit_i(rx_bit_i), .tx_take_i(tx_take_i), .tx_valid_o(tx_valid_o),
        .tx_bit_o(tx_bit_o), .outputs_on_o(outputs_on_o),
        .shutdown_o(shutdown_o), .event_msg_o(event_msg_o),
        .status_o(status_o));
    ssm_mgr u_mgr (.clk_i(clk_i), .tx_valid_i(tx_valid_o),
        .tx_bit_i(tx_bit_o), .frame_start_o(frame_start_i),
        .frame_stop_o(frame_stop_i), .bit_valid_o(rx_bit_valid_i),
        .bit_o(rx_bit_i), .take_o(tx_take_i));
    task automatic finish_test();
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp8(input string what, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic cmp1(input string what, input logic e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %b, seen %b", what, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] b[$]);
        u_mgr.send(b);
        tick(3);
    endtask
    task automatic pulse_fault(input logic ot);
        fault_i = !ot;
        overtemp_fault_i = ot;
        tick(1);
        fault_i = 1'b0;
        overtemp_fault_i = 1'b0;
    endtask
    task automatic t_reset();
        cmp8("status", 8'h03, status_o);
        cmp1("outputs", 1'b0, outputs_on_o);
        cmp1("tx_valid", 1'b0, tx_valid_o);
        reset_n_i = 1'b1;
        enable_n_i = 1'b0;
        tick(4);
        cmp8("status", 8'h02, status_o);
        cmp1("outputs", 1'b1, outputs_on_o);
        inhibit_n_i = 1'b0;
        tick(4);
        cmp8("status", 8'h00, status_o);
        cmp1("outputs", 1'b0, outputs_on_o);
        inhibit_n_i = 1'b1;
        tick(4);
    endtask
    task automatic t_write();
        logic [7:0] d[3] = '{8'hdf, 8'h18, 8'h10};
        logic [7:0] e[3] = '{8'h5e, 8'h1a, 8'h12};
        logic on[3] = '{1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 3; i++) begin
            wr('{SSM_CMD_STATUS, d[i]});
            cmp8("status", e[i], status_o);
            cmp1("outputs", on[i], outputs_on_o);
        end
    endtask
    task automatic t_override();
        wr('{SSM_CMD_STATUS, 8'hd8, 8'hd8, 8'hd9});
        cmp8("status", 8'h12, status_o);
        wr('{SSM_CMD_STATUS, 8'hd8, 8'hd8, 8'hd8});
        cmp8("status", 8'hda, status_o);
        pulse_fault(1'b0);
        cmp1("event", 1'b1, event_msg_o);
        cmp1("shutdown", 1'b0, shutdown_o);
        cmp1("outputs", 1'b1, outputs_on_o);
        cmp8("status", 8'h9a, status_o);
        u_mgr.send('{SSM_CMD_STATUS});
        u_mgr.get(3);
        cmp8("reply cmd", 8'h55, u_mgr.rx_q[0]);
        cmp8("reply status", 8'h9a, u_mgr.rx_q[1]);
        cmp8("reply sum", 8'h00 - 8'h55 - 8'h9a, u_mgr.rx_q[2]);
        cmp1("tx_valid", 1'b0, tx_valid_o);
    endtask
    task automatic t_faults();
        wr('{SSM_CMD_STATUS, 8'h18});
        pulse_fault(1'b0);
        cmp1("event", 1'b1, event_msg_o);
        cmp1("shutdown", 1'b1, shutdown_o);
        cmp1("outputs", 1'b0, outputs_on_o);
        tick(RETRY - 1);
        cmp1("shutdown", 1'b1, shutdown_o);
        tick(1);
        cmp1("shutdown", 1'b0, shutdown_o);
        wr('{SSM_CMD_STATUS, 8'h38});
        pulse_fault(1'b1);
        cmp8("status", 8'h1a, status_o);
        tick(2 * RETRY);
        cmp1("shutdown", 1'b1, shutdown_o);
        wr('{SSM_CMD_STATUS, 8'h98, 8'h98, 8'h98});
        cmp1("shutdown", 1'b0, shutdown_o);
        cmp8("status", 8'h9a, status_o);
    endtask
    task automatic t_sdr();
        logic [7:0] id[10] = '{8'h02, 8'h03, 8'h04, 8'h16, 8'h18, 8'h12,
            8'h13, 8'h09, 8'h10, 8'h17};
        // Supported, type, event, M, B, K1, K2; the manager scales by these
        logic [55:0] rec[10] = '{56'h01f20400000000, 56'h01020500000000,
            56'h01f36f00000000, 56'h010b01280000ff, 56'h010b010a0000ff,
            56'h01010101140100, 56'h01010101140100, 56'h0, 56'h0, 56'h0};
        logic [7:0] sum;
        logic [7:0] fld;
        logic [7:0] rsp[$];
        for (int i = 0; i < 10; i++) begin
            u_mgr.send('{SSM_CMD_SDR, id[i]});
            u_mgr.get(10);
            rsp = u_mgr.rx_q;
            sum = 8'h5a + id[i];
            cmp8("sdr cmd", 8'h5a, rsp[0]);
            cmp8("sdr id", id[i], rsp[1]);
            for (int f = 0; f < 7; f++) begin
                fld = rec[i][55-8*f -: 8];
                sum = sum + fld;
                cmp8("sdr field", fld, rsp[2+f]);
            end
            cmp8("sdr sum", 8'h00 - sum, rsp[9]);
        end
    endtask
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
    initial begin
        tick(8);
        t_reset();
        t_write();
        t_override();
        t_faults();
        t_sdr();
        finish_test();
    end
endmodule
